// >>> verilog/mstd_pkg.sv
package mstd_pkg;
    // --------------------------------------------------------------
    // Field widths and reset values.
    // --------------------------------------------------------------
    localparam int unsigned POS_W = 7;
    localparam logic [6:0] POS_RST = 7'h00;
    localparam int unsigned MODE_W = 3;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam int unsigned CUR_W = 5;
    localparam logic [4:0] CUR_RST = 5'h00;
    localparam int unsigned BEMF_W = 8;
    localparam logic [7:0] BEMF_RST = 8'h00;

    // --------------------------------------------------------------
    // Timing.
    // --------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned OPEN_TIME_MS = 200;
    localparam int unsigned OPEN_CYCLES = OPEN_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_TIME_US = 100;
    localparam int unsigned POR_CYCLES = POR_TIME_US * CLK_MHZ;
    localparam int unsigned PWM_PERIOD_CYCLES = 64;
endpackage

// >>> verilog/mstd_sync.sv
`timescale 1ns/1ns
module mstd_sync #(
    parameter int unsigned WIDTH = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // --------------------------------------------------------------
    // Two flip-flop synchroniser per bit.
    // --------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    meta_q[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule

// >>> verilog/mstd_core.sv
`timescale 1ns/1ns
// Functional notes
// - Every step edge loads position, even disabled; a finer-mode edge only snaps it, and mode 7 adds 0.
// - Polarity bit picks rising or falling edge.
// - Direction comes from pin and control bit.
// - Position is 7-bit thirty-second steps.
// - Readable position updates right after trigger.
// - New step mode applies at next step.
// - Finer mode snaps to nearest grid point.
// - Coarser mode keeps current offset.
// - Peak code applied at next PWM period.
// - Sample back-EMF at end of each zero crossing while pwm_sample_hold high.
// - Transparent follows coil, else holds samples.
// - Divider bit selects half or quarter.
// - Thermal warning flag follows warning input.
// - Shutdown latches, drivers off, clears on read once warning input low.
// - Overcurrent latches per transistor, drivers off.
// - Full duty over 200 ms flags open coil.
// - Unreachable current flags, keeps drive unless open_load_in also set.
// - Pump fault flag while pump below threshold.
// - Fault output low when any flag set.
// - Host reset held low after power-up.
// - Hard reset clears all but host reset sequencer and pin synchronisers while high.
module mstd_core #(
    parameter int unsigned OPEN_CYC = mstd_pkg::OPEN_CYCLES,
    parameter int unsigned POR_CYC = mstd_pkg::POR_CYCLES,
    parameter int unsigned PWM_CYC = mstd_pkg::PWM_PERIOD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hard_reset_input,
    input wire logic step_pulse_input,
    input wire logic dir_pin,
    input wire logic rotation_sense_bit,
    input wire logic drive_enable_bit,
    input wire logic step_edge_polarity_bit,
    input wire logic [mstd_pkg::MODE_W-1:0] step_mode,
    input wire logic [mstd_pkg::CUR_W-1:0] peak_amplitude_code,
    input wire logic bemf_transparent_bit,
    input wire logic bemf_divider_bit,
    input wire logic pwm_sample_hold,
    input wire logic [1:0] coil_zero_cross,
    input wire logic [mstd_pkg::BEMF_W-1:0] coil_voltage,
    input wire logic temp_warning_in,
    input wire logic temp_shutdown_in,
    input wire logic [3:0] ovc_x_in,
    input wire logic [3:0] ovc_y_in,
    input wire logic [1:0] full_duty_in,
    input wire logic [1:0] open_load_in,
    input wire logic pump_low_in,
    input wire logic status_read,
    input wire logic status_clear,
    output logic [mstd_pkg::POS_W-1:0] translator_position,
    output logic [mstd_pkg::POS_W-1:0] status_reg_three,
    output logic [mstd_pkg::CUR_W-1:0] applied_peak_code,
    output logic [mstd_pkg::BEMF_W-1:0] back_emf_output,
    output logic thermal_warning_flag,
    output logic thermal_shutdown_flag,
    output logic [3:0] overcurrent_flags_coil_x,
    output logic [3:0] overcurrent_flags_coil_y,
    output logic coil_x_unreached_flag,
    output logic coil_y_unreached_flag,
    output logic pump_fault_flag,
    output logic [1:0] coil_drive_en,
    output logic fault_out_n,
    output logic host_reset_out_n,
    output logic host_reset_oe
);
    import mstd_pkg::*;

    typedef enum logic [2:0] {
        MSTD_POR = 3'h1,
        MSTD_RUN = 3'h2,
        MSTD_HOLD = 3'h4
    } mstd_state_t;

    // --------------------------------------------------------------
    // Reset combination and pin synchronisers.
    // --------------------------------------------------------------
    logic clr_sync;
    logic step_sync;
    logic dir_sync;
    logic [2:0] pins_sync;
    logic srst;

    mstd_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({hard_reset_input, dir_pin, step_pulse_input}),
        .sync_out(pins_sync)
    );
    assign step_sync = pins_sync[0];
    assign dir_sync = pins_sync[1];
    assign clr_sync = pins_sync[2];
    assign srst = rst | clr_sync;

    // --------------------------------------------------------------
    // Step edge detection and direction.
    // --------------------------------------------------------------
    logic step_prev_q;
    logic step_edge;
    logic dir_up;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            step_prev_q <= 1'b0;
        end else begin
            step_prev_q <= step_sync;
        end
    end

    assign step_edge = step_edge_polarity_bit ? (step_prev_q & ~step_sync)
                                              : (~step_prev_q & step_sync);
    assign dir_up = dir_sync ^ rotation_sense_bit;

    // --------------------------------------------------------------
    // Translator with step mode synchronisation.
    // --------------------------------------------------------------
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] pos_d;
    logic [MODE_W-1:0] mode_q;
    logic [POS_W-1:0] step_size;
    logic [POS_W-1:0] half_size;
    logic [POS_W-1:0] grid_mask;
    logic [POS_W-1:0] snapped;
    logic finer;

    // Mode 0 is thirty-second steps; each higher mode doubles the step up to 64 at mode 6; mode 7 gives a step of 0.
    assign step_size = 7'h01 << step_mode;
    assign half_size = step_size >> 1;
    assign grid_mask = ~(step_size - 7'h01);
    assign finer = step_mode < mode_q;
    assign snapped = (pos_q + half_size) & grid_mask;
    assign pos_d = finer ? snapped
                         : (dir_up ? pos_q + step_size : pos_q - step_size);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pos_q <= POS_RST;
            mode_q <= MODE_RST;
        end else if (step_edge) begin
            pos_q <= pos_d;
            mode_q <= step_mode;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            translator_position <= POS_RST;
            status_reg_three <= POS_RST;
        end else begin
            translator_position <= pos_d & {POS_W{step_edge}} | pos_q & {POS_W{~step_edge}};
            status_reg_three <= step_edge ? pos_d : pos_q;
        end
    end

    // --------------------------------------------------------------
    // Peak amplitude applied on PWM period boundary.
    // --------------------------------------------------------------
    logic [$clog2(PWM_CYC)-1:0] pwm_cnt_q;
    logic pwm_wrap;

    assign pwm_wrap = pwm_cnt_q == $bits(pwm_cnt_q)'(PWM_CYC - 1);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwm_cnt_q <= '0;
            applied_peak_code <= CUR_RST;
        end else begin
            pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + 1'b1;
            if (pwm_wrap) begin
                applied_peak_code <= peak_amplitude_code;
            end
        end
    end

    // --------------------------------------------------------------
    // Back-EMF sampling and scaling.
    // --------------------------------------------------------------
    logic [BEMF_W-1:0] scaled;
    logic [BEMF_W-1:0] sample_q;
    logic [1:0] zc_prev_q;
    logic zc_end;
    logic sample_now;

    assign scaled = bemf_divider_bit ? (coil_voltage >> 2) : (coil_voltage >> 1);
    assign zc_end = |(zc_prev_q & ~coil_zero_cross);
    assign sample_now = zc_end & pwm_sample_hold;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zc_prev_q <= 2'h0;
            sample_q <= BEMF_RST;
            back_emf_output <= BEMF_RST;
        end else begin
            zc_prev_q <= coil_zero_cross;
            if (sample_now) begin
                sample_q <= scaled;
            end
            back_emf_output <= bemf_transparent_bit ? scaled
                             : (sample_now ? scaled : sample_q);
        end
    end

    // --------------------------------------------------------------
    // Fault flags.
    // --------------------------------------------------------------
    logic [31:0] open_cnt_q [2];
    logic [1:0] open_q;
    logic [1:0] open_hit;
    logic tsd_q;
    logic [7:0] ovc_q;
    logic [7:0] ovc_in;

    assign ovc_in = {ovc_y_in, ovc_x_in};

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_coil
            assign open_hit[c] = open_cnt_q[c] >= OPEN_CYC;
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    open_cnt_q[c] <= 32'h0;
                    open_q[c] <= 1'b0;
                end else begin
                    if (!full_duty_in[c]) begin
                        open_cnt_q[c] <= 32'h0;
                    end else if (!open_hit[c]) begin
                        open_cnt_q[c] <= open_cnt_q[c] + 32'h1;
                    end
                    if (open_hit[c]) begin
                        open_q[c] <= 1'b1;
                    end else if (status_clear) begin
                        open_q[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tsd_q <= 1'b0;
            ovc_q <= 8'h00;
        end else begin
            if (temp_shutdown_in) begin
                tsd_q <= 1'b1;
            end else if (status_read && !temp_warning_in) begin
                tsd_q <= 1'b0;
            end
            ovc_q <= ovc_in | (status_clear ? 8'h00 : ovc_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            thermal_warning_flag <= 1'b0;
            thermal_shutdown_flag <= 1'b0;
            overcurrent_flags_coil_x <= 4'h0;
            overcurrent_flags_coil_y <= 4'h0;
            coil_x_unreached_flag <= 1'b0;
            coil_y_unreached_flag <= 1'b0;
            pump_fault_flag <= 1'b1;
            coil_drive_en <= 2'h0;
            fault_out_n <= 1'b0;
        end else begin
            thermal_warning_flag <= temp_warning_in;
            thermal_shutdown_flag <= tsd_q;
            overcurrent_flags_coil_x <= ovc_q[3:0];
            overcurrent_flags_coil_y <= ovc_q[7:4];
            coil_x_unreached_flag <= open_q[0];
            coil_y_unreached_flag <= open_q[1];
            pump_fault_flag <= pump_low_in;
            for (int k = 0; k < 2; k++) begin
                coil_drive_en[k] <= drive_enable_bit & ~tsd_q & ~|ovc_q
                                    & ~(open_q[k] & open_load_in[k]);
            end
            fault_out_n <= ~(temp_warning_in | tsd_q | |ovc_q | |open_q | pump_low_in);
        end
    end

    // --------------------------------------------------------------
    // Host reset sequencer (power-on only, not hard reset).
    // --------------------------------------------------------------
    mstd_state_t state_q;
    mstd_state_t state_d;
    logic [$clog2(POR_CYC+1)-1:0] por_cnt_q;
    logic por_done;

    assign por_done = por_cnt_q == $bits(por_cnt_q)'(POR_CYC);

    always_comb begin
        state_d = state_q;
        case (state_q)
            MSTD_POR: state_d = por_done ? MSTD_RUN : MSTD_POR;
            MSTD_RUN: state_d = MSTD_RUN;
            default: state_d = MSTD_POR;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= MSTD_POR;
            por_cnt_q <= '0;
            host_reset_out_n <= 1'b0;
            host_reset_oe <= 1'b1;
        end else begin
            state_q <= state_d;
            if (!por_done) begin
                por_cnt_q <= por_cnt_q + 1'b1;
            end
            host_reset_out_n <= 1'b0;
            host_reset_oe <= state_d != MSTD_RUN;
        end
    end

    // --------------------------------------------------------------
    // Checks.
    // --------------------------------------------------------------
    a_step_moves: assert property (@(posedge ref_clk) disable iff (srst)
        step_edge && !finer |=> pos_q == $past(pos_d)) else $error("step lost");
    a_pos_visible: assert property (@(posedge ref_clk) disable iff (srst)
        step_edge |=> status_reg_three == pos_q) else $error("pos late");
    a_fault_low: assert property (@(posedge ref_clk) disable iff (srst)
        tsd_q |=> !fault_out_n) else $error("fault not shown");
    a_ovc_off: assert property (@(posedge ref_clk) disable iff (srst)
        |ovc_q |=> coil_drive_en == 2'h0) else $error("drive on at ovc");
    a_tsd_off: assert property (@(posedge ref_clk) disable iff (srst)
        tsd_q |=> coil_drive_en == 2'h0) else $error("drive on at tsd");
    a_peak_sync: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(pwm_wrap) |-> $stable(applied_peak_code)) else $error("peak early");
    a_bemf_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !bemf_transparent_bit && !sample_now |=> back_emf_output == $past(sample_q))
        else $error("bemf not held");
    a_pump_flag: assert property (@(posedge ref_clk) disable iff (srst)
        pump_low_in |=> pump_fault_flag) else $error("pump flag");
    a_snap_grid: assert property (@(posedge ref_clk) disable iff (srst)
        step_edge && finer |=> (pos_q & ~$past(grid_mask)) == 7'h00) else $error("off grid");
    a_open_drive: assert property (@(posedge ref_clk) disable iff (srst)
        open_q[0] && open_load_in[0] |=> !coil_drive_en[0]) else $error("open coil driven");
endmodule

// >>> testbench/mstd_host_model.sv
`timescale 1ns/1ns
module mstd_host_model (
    input wire logic ref_clk,
    output logic step_pulse_input,
    output logic dir_pin,
    output logic status_read,
    output logic status_clear
);
    initial begin
        step_pulse_input = 1'b0;
        dir_pin = 1'b0;
        status_read = 1'b0;
        status_clear = 1'b0;
    end

    // Holds the step pin at a level for n cycles, with no lower limit on n.
    task automatic drive_step(input logic lvl, input int n);
        @(posedge ref_clk) step_pulse_input <= lvl;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_dir(input logic lvl);
        @(posedge ref_clk) dir_pin <= lvl;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // Issues a single one-cycle status access, never a polling loop.
    task automatic strobe(input logic clr);
        @(posedge ref_clk);
        if (clr) begin
            status_clear <= 1'b1;
        end else begin
            status_read <= 1'b1;
        end
        @(posedge ref_clk);
        status_clear <= 1'b0;
        status_read <= 1'b0;
    endtask
endmodule

// >>> testbench/test_microstep_translator_diagnostics.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_microstep_translator_diagnostics;
    import mstd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hard_reset_input = 1'b0, rotation_sense_bit = 1'b0, drive_enable_bit = 1'b0;
    logic step_edge_polarity_bit = 1'b0, bemf_transparent_bit = 1'b0, bemf_divider_bit = 1'b0;
    logic pwm_sample_hold = 1'b0, temp_warning_in = 1'b0, temp_shutdown_in = 1'b0;
    logic pump_low_in = 1'b1;
    logic [2:0] step_mode = 3'h0;
    logic [4:0] peak_amplitude_code = 5'h00;
    logic [1:0] coil_zero_cross = 2'h0, full_duty_in = 2'h0, open_load_in = 2'h0;
    logic [7:0] coil_voltage = 8'h00;
    logic [3:0] ovc_x_in = 4'h0, ovc_y_in = 4'h0;
    logic step_pulse_input, dir_pin, status_read, status_clear;
    logic [6:0] translator_position, status_reg_three, p, df;
    logic [4:0] applied_peak_code;
    logic [7:0] back_emf_output;
    logic [3:0] overcurrent_flags_coil_x, overcurrent_flags_coil_y;
    logic [1:0] coil_drive_en;
    logic thermal_warning_flag, thermal_shutdown_flag, coil_x_unreached_flag;
    logic coil_y_unreached_flag, pump_fault_flag, fault_out_n, host_reset_out_n, host_reset_oe;
    int num_errors = 0;
    int num_checks = 0;
    int d;

    always #4 ref_clk = ~ref_clk;

    mstd_host_model host (.ref_clk, .step_pulse_input, .dir_pin, .status_read, .status_clear);

    mstd_core #(.OPEN_CYC(20), .POR_CYC(8)) dut (
        .ref_clk, .rst, .hard_reset_input, .step_pulse_input, .dir_pin, .rotation_sense_bit,
        .drive_enable_bit, .step_edge_polarity_bit, .step_mode, .peak_amplitude_code,
        .bemf_transparent_bit, .bemf_divider_bit, .pwm_sample_hold, .coil_zero_cross,
        .coil_voltage, .temp_warning_in, .temp_shutdown_in, .ovc_x_in, .ovc_y_in,
        .full_duty_in, .open_load_in, .pump_low_in, .status_read, .status_clear,
        .translator_position, .status_reg_three, .applied_peak_code, .back_emf_output,
        .thermal_warning_flag, .thermal_shutdown_flag, .overcurrent_flags_coil_x,
        .overcurrent_flags_coil_y, .coil_x_unreached_flag, .coil_y_unreached_flag,
        .pump_fault_flag, .coil_drive_en, .fault_out_n, .host_reset_out_n, .host_reset_oe
    );

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic step1();
        host.drive_step(1'b1, 6);
        host.drive_step(1'b0, 6);
    endtask

    task automatic zc(input int i);
        @(posedge ref_clk) coil_zero_cross[i] <= 1'b1;
        wt(3);
        @(posedge ref_clk) coil_zero_cross[i] <= 1'b0;
        wt(4);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset();
        `CHK("position", 7'h00, status_reg_three)
        `CHK("pump flag", 1'b1, pump_fault_flag)
        `CHK("fault out", 1'b0, fault_out_n)
        `CHK("host rst oe", 1'b1, host_reset_oe)
        wt(12);
        `CHK("host rst oe", 1'b0, host_reset_oe)
        `CHK("host rst lvl", 1'b0, host_reset_out_n)
    endtask

    task automatic t_dir();
        p = status_reg_three;
        step1();
        df = status_reg_three - p;
        `CHK("step delta", 1'b1, df == 7'h01 || df == 7'h7f)
        d = (df == 7'h01) ? 1 : -1;
        host.set_dir(1'b1);
        @(posedge ref_clk) rotation_sense_bit <= 1'b1;
        step1();
        `CHK("pin and bit", 7'(p + 2 * d), status_reg_three)
        @(posedge ref_clk) rotation_sense_bit <= 1'b0;
        step1();
        `CHK("pin only", 7'(p + d), status_reg_three)
        `CHK("position", 7'(p + d), translator_position)
        host.set_dir(1'b0);
    endtask

    task automatic t_pol();
        @(posedge ref_clk) step_edge_polarity_bit <= 1'b1;
        p = status_reg_three;
        host.drive_step(1'b1, 6);
        `CHK("rise ignored", p, status_reg_three)
        host.drive_step(1'b0, 6);
        `CHK("fall step", 7'(p + d), status_reg_three)
        @(posedge ref_clk) step_edge_polarity_bit <= 1'b0;
    endtask

    task automatic t_mode();
        while (status_reg_three[1:0] != 2'b11) step1();
        p = status_reg_three;
        @(posedge ref_clk) step_mode <= 3'h2;
        wt(6);
        `CHK("no move on write", p, status_reg_three)
        step1();
        `CHK("offset kept", 7'(p + 4 * d), status_reg_three)
        p = status_reg_three;
        @(posedge ref_clk) step_mode <= 3'h1;
        step1();
        `CHK("finer snap", 7'(p + 1), status_reg_three)
        p = status_reg_three;
        @(posedge ref_clk) step_mode <= 3'h0;
        step1();
        `CHK("finer on grid", p, status_reg_three)
        while (status_reg_three[1:0] != 2'b00) step1();
        p = status_reg_three;
        @(posedge ref_clk) step_mode <= 3'h2;
        step1();
        `CHK("shared point", 7'(p + 4 * d), status_reg_three)
        @(posedge ref_clk) step_mode <= 3'h5;
        step1();
        `CHK("full step", 7'(p + 36 * d), status_reg_three)
        @(posedge ref_clk) step_mode <= 3'h0;
    endtask

    task automatic t_peak();
        @(posedge ref_clk) peak_amplitude_code <= 5'h15;
        for (int i = 0; i < 70 && applied_peak_code !== 5'h15; i++) wt(1);
        `CHK("peak code", 5'h15, applied_peak_code)
        @(posedge ref_clk) peak_amplitude_code <= 5'h0a;
        wt(1);
        `CHK("peak not early", 5'h15, applied_peak_code)
        for (int i = 0; i < 70 && applied_peak_code !== 5'h0a; i++) wt(1);
        `CHK("peak code two", 5'h0a, applied_peak_code)
    endtask

    task automatic t_bemf();
        @(posedge ref_clk) bemf_transparent_bit <= 1'b1;
        coil_voltage <= 8'hc8;
        wt(4);
        `CHK("bemf half", 8'h64, back_emf_output)
        @(posedge ref_clk) bemf_divider_bit <= 1'b1;
        wt(4);
        `CHK("bemf quarter", 8'h32, back_emf_output)
        @(posedge ref_clk) bemf_transparent_bit <= 1'b0;
        pwm_sample_hold <= 1'b1;
        coil_voltage <= 8'h40;
        zc(0);
        `CHK("bemf x sample", 8'h10, back_emf_output)
        @(posedge ref_clk) coil_voltage <= 8'h80;
        wt(4);
        `CHK("bemf held", 8'h10, back_emf_output)
        zc(1);
        `CHK("bemf y sample", 8'h20, back_emf_output)
        @(posedge ref_clk) pwm_sample_hold <= 1'b0;
        coil_voltage <= 8'ha0;
        zc(0);
        `CHK("bemf no strobe", 8'h20, back_emf_output)
        @(posedge ref_clk) bemf_transparent_bit <= 1'b1;
        bemf_divider_bit <= 1'b0;
        wt(4);
        `CHK("bemf half again", 8'h50, back_emf_output)
    endtask

    task automatic t_fault();
        @(posedge ref_clk) pump_low_in <= 1'b0;
        drive_enable_bit <= 1'b1;
        wt(4);
        `CHK("pump clear", 1'b0, pump_fault_flag)
        `CHK("no fault", 1'b1, fault_out_n)
        `CHK("drive on", 2'b11, coil_drive_en)
        @(posedge ref_clk) temp_warning_in <= 1'b1;
        wt(4);
        `CHK("warn flag", 1'b1, thermal_warning_flag)
        `CHK("warn fault", 1'b0, fault_out_n)
        @(posedge ref_clk) temp_shutdown_in <= 1'b1;
        wt(3);
        @(posedge ref_clk) temp_shutdown_in <= 1'b0;
        wt(3);
        `CHK("tsd flag", 1'b1, thermal_shutdown_flag)
        `CHK("tsd drive off", 2'b00, coil_drive_en)
        host.strobe(1'b0);
        wt(2);
        `CHK("tsd kept hot", 1'b1, thermal_shutdown_flag)
        @(posedge ref_clk) temp_warning_in <= 1'b0;
        wt(3);
        host.strobe(1'b0);
        wt(2);
        `CHK("tsd cleared", 1'b0, thermal_shutdown_flag)
        `CHK("fault gone", 1'b1, fault_out_n)
        @(posedge ref_clk) ovc_x_in <= 4'h4;
        ovc_y_in <= 4'h1;
        wt(3);
        @(posedge ref_clk) ovc_x_in <= 4'h0;
        ovc_y_in <= 4'h0;
        wt(8);
        `CHK("ovc x", 4'h4, overcurrent_flags_coil_x)
        `CHK("ovc y", 4'h1, overcurrent_flags_coil_y)
        `CHK("ovc drive off", 2'b00, coil_drive_en)
        `CHK("ovc fault", 1'b0, fault_out_n)
        host.strobe(1'b1);
        wt(2);
        `CHK("ovc cleared", 4'h0, overcurrent_flags_coil_x)
        `CHK("drive back", 2'b11, coil_drive_en)
        @(posedge ref_clk) full_duty_in <= 2'b01;
        wt(14);
        `CHK("early open", 1'b0, coil_x_unreached_flag)
        wt(12);
        `CHK("open x", 1'b1, coil_x_unreached_flag)
        `CHK("x kept driving", 2'b11, coil_drive_en)
        `CHK("open fault", 1'b0, fault_out_n)
        @(posedge ref_clk) full_duty_in <= 2'b10;
        open_load_in <= 2'b10;
        wt(26);
        `CHK("open y", 1'b1, coil_y_unreached_flag)
        `CHK("y drive off", 2'b01, coil_drive_en)
        @(posedge ref_clk) full_duty_in <= 2'b00;
        open_load_in <= 2'b00;
        host.strobe(1'b1);
        wt(2);
        `CHK("open cleared", 1'b0, coil_x_unreached_flag)
    endtask

    task automatic t_hard();
        @(posedge ref_clk) hard_reset_input <= 1'b1;
        drive_enable_bit <= 1'b0;
        pump_low_in <= 1'b1;
        wt(5);
        `CHK("hard clr pos", 7'h00, status_reg_three)
        `CHK("host rst idle", 1'b0, host_reset_oe)
        @(posedge ref_clk) hard_reset_input <= 1'b0;
        wt(4);
        step1();
        `CHK("runs again", 7'(d), status_reg_three)
        `CHK("step while off", 2'b00, coil_drive_en)
        `CHK("pump low again", 1'b1, pump_fault_flag)
        `CHK("fault again", 1'b0, fault_out_n)
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        wt(1);
        t_reset();
        t_dir();
        t_pol();
        t_mode();
        t_peak();
        t_bemf();
        t_fault();
        t_hard();
        close_out();
    end

    initial begin
        wt(5000);
        num_errors++;
        close_out();
    end
endmodule
